//--- verilog/tai_pkg.sv
// constants and types for the transceiver pin and rate configuration
package tai_pkg;
	localparam logic [5:0] IDX_CCA = 6'h1C;
	localparam logic [5:0] IDX_RSVD = 6'h1D;
	localparam logic [5:0] IDX_PINRATE = 6'h1E;
	localparam logic [5:0] IDX_REV = 6'h1F;
	localparam logic [5:0] IDX_LINK = 6'h20;
	localparam logic [5:0] IDX_STAT = 6'h21;
	localparam logic [7:0] CCA_RESET = 8'h00;
	localparam logic [7:0] PINRATE_RESET = 8'h09;
	localparam logic [5:0] LINK_RESET = 6'h00;
	localparam int CCA_SD_BAUD = 2;
	localparam int CCA_CS_BAUD = 1;
	localparam int CCA_RSSI = 0;
	localparam int PR_ANT_FN = 7;
	localparam int PR_TXD_FN = 6;
	localparam int PR_CMD_FN = 5;
	localparam logic [7:0] PR_RSVD_MASK = 8'h10;
	localparam int PR_EXT_TXC = 3;
	localparam int PR_RATE_MSB = 2;
	localparam int PR_RATE_LSB = 0;
	localparam int LC_FAST = 0;
	localparam int LC_ANT_EN = 1;
	localparam int LC_TXD_EN = 2;
	localparam int LC_CMD_EN = 3;
	localparam int LC_SW_EN = 4;
	localparam int LC_RX_EN = 5;
	localparam logic [11:0] RATIO_20 = 12'h014;
	localparam logic [11:0] RATIO_40 = 12'h028;
	localparam logic [11:0] RATIO_80 = 12'h050;
	localparam logic [11:0] RATIO_160 = 12'h0A0;
	localparam logic [11:0] RATIO_200 = 12'h0C8;
	localparam logic [11:0] RATIO_400 = 12'h190;
	localparam logic [11:0] RATIO_2000 = 12'h7D0;
	localparam logic [11:0] RATIO_4000 = 12'hFA0;
	localparam logic [4:0] OVERSAMPLE = 5'h14;
	localparam logic [4:0] PHASE_LAST = OVERSAMPLE - 5'h01;
	localparam logic [4:0] TXC_HIGH = 5'h0A;
	localparam logic [4:0] PREFILL = 5'h08;
	localparam logic [4:0] FIFO_DEPTH = 5'h10;

	typedef enum logic [1:0] {EB_IDLE, EB_FILL, EB_RUN} elastic_state_t;

	// zero marks a reserved code
	function automatic logic [11:0] rate_ratio(
		input logic [2:0] code,
		input logic fast
	);
		logic [11:0] r;
		r = 12'h000;
		case (code)
			3'h0: r = fast ? RATIO_20 : 12'h000;
			3'h1: r = fast ? RATIO_40 : RATIO_20;
			3'h2: r = fast ? RATIO_80 : RATIO_40;
			3'h3: r = fast ? RATIO_160 : RATIO_80;
			3'h5: r = fast ? RATIO_400 : RATIO_200;
			3'h6: r = fast ? RATIO_4000 : RATIO_2000;
			default: r = 12'h000;
		endcase
		return r;
	endfunction : rate_ratio
endpackage : tai_pkg

//--- verilog/tai_rate_pin_config.sv
// transceiver pin function, data-rate divider and revision register bank
// Operation
// - baud-use set: stop-diversity count feeds decision
// - baud-use clear: stop-diversity count ignored
// - carrier baud count gated into channel assessment
// - signal-strength compare feeds both decisions
// - antenna pin from function, enable, switch, strap
// - data pin from function, enable, strap
// - command pin from function, enable, receive, strap
// - internal clock: tx clock pin drives divided clock
// - external clock: pin paces, elastic FIFO inserted
// - external clock delays first data eight bits
// - slow input clock rate codes and divisors
// - fast input clock rate codes and divisors
// - DPLL tick at twenty times bit rate
// - transmit strobe at selected bit rate
// - read-only revision byte
`timescale 1ns/100ps
`default_nettype none
module tai_rate_pin_config #(
	// arbitrary value, replace per silicon revision
	parameter logic [7:0] REVISION = 8'h5A
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic baud_stop_div_hit,
	input wire logic baud_carrier_hit,
	input wire logic rssi_above_floor,
	output logic stop_div_term,
	output logic cca_term,
	input wire logic diversity_antenna,
	input wire logic transmit_start_bit,
	input wire logic tx_data_bit,
	input wire logic tx_command_level,
	input wire logic receive_active,
	output logic dpll_clock_tick,
	output logic tx_bit_strobe,
	input wire logic bus_mode_strap,
	output logic antenna_select_pin_n_o,
	output logic antenna_select_pin_oe,
	output logic tx_serial_data_pin_n_o,
	output logic tx_serial_data_pin_oe,
	output logic tx_command_pin_o,
	output logic tx_command_pin_oe,
	input wire logic tx_clock_pin_i,
	output logic tx_clock_pin_o,
	output logic tx_clock_pin_oe
);
	typedef struct packed {
		logic [1:0] rst_q;
		logic [1:0] strap_q;
		logic [2:0] txc_q;
		logic [7:0] cca;
		logic [7:0] pin_rate;
		logic [5:0] lc;
		logic [7:0] rdata;
		logic [7:0] fine;
		logic [4:0] phase;
		logic dtick;
		logic btick;
		logic txc_o;
		tai_pkg::elastic_state_t eb;
		logic [15:0] fifo;
		logic [3:0] wr;
		logic [3:0] rd;
		logic [4:0] level;
		logic ser;
		logic stop;
		logic cca_o;
		logic ant_o;
		logic ant_oe;
		logic txd_o;
		logic txd_oe;
		logic cmd_o;
		logic cmd_oe;
		logic [11:0] gap;
		logic gap_ok;
		logic [4:0] dcnt;
	} state_t;

	localparam state_t S_RST = '{
		cca: tai_pkg::CCA_RESET,
		pin_rate: tai_pkg::PINRATE_RESET,
		lc: tai_pkg::LINK_RESET,
		eb: tai_pkg::EB_IDLE,
		default: '0
	};

	state_t s;
	state_t n;
	logic [5:0] idx;
	logic aligned;
	logic wr_acc;
	logic hit;
	logic [7:0] rd_val;
	logic [2:0] code;
	logic ext;
	logic fast;
	logic pcm;
	logic [11:0] ratio;
	logic [11:0] div_w;
	logic [7:0] div;
	logic rsv;
	logic edge_ext;
	logic push;
	logic pop;

	assign idx = paddr[7:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign wr_acc = psel && penable && pwrite && hit;
	assign code = s.pin_rate[tai_pkg::PR_RATE_MSB:tai_pkg::PR_RATE_LSB];
	assign ext = s.pin_rate[tai_pkg::PR_EXT_TXC];
	assign fast = s.lc[tai_pkg::LC_FAST];
	assign pcm = s.strap_q[1];
	assign ratio = tai_pkg::rate_ratio(code, fast);
	assign div_w = ratio / {7'h00, tai_pkg::OVERSAMPLE};
	assign div = div_w[7:0];
	assign rsv = (ratio == 12'h000);
	// synchronised edge of the far-end clock; first stage is left alone
	assign edge_ext = s.txc_q[1] && !s.txc_q[2];

	// zero-wait slave: every transfer completes in its access cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = {24'h000000, s.rdata};

	always_comb begin
		hit = aligned;
		rd_val = 8'h00;
		if (idx == tai_pkg::IDX_CCA) begin
			rd_val = s.cca;
		end else if (idx == tai_pkg::IDX_RSVD) begin
			rd_val = 8'h00;
		end else if (idx == tai_pkg::IDX_PINRATE) begin
			rd_val = s.pin_rate;
		end else if (idx == tai_pkg::IDX_REV) begin
			rd_val = REVISION;
		end else if (idx == tai_pkg::IDX_LINK) begin
			rd_val = {2'h0, s.lc};
		end else if (idx == tai_pkg::IDX_STAT) begin
			rd_val = {1'b0, s.level, pcm, rsv};
		end else begin
			hit = 1'b0;
		end
		if (!aligned) begin
			rd_val = 8'h00;
		end
	end

	always_comb begin
		n = s;
		push = 1'b0;
		pop = 1'b0;
		n.strap_q = {s.strap_q[0], bus_mode_strap};
		n.txc_q = {s.txc_q[1:0], tx_clock_pin_i};
		n.dtick = 1'b0;
		n.btick = 1'b0;
		// captured in setup so read data leaves a flop
		if (psel && !penable) begin
			n.rdata = rd_val;
		end
		if (wr_acc) begin
			if (idx == tai_pkg::IDX_CCA) begin
				n.cca = pwdata[7:0];
			end else if (idx == tai_pkg::IDX_PINRATE) begin
				n.pin_rate = pwdata[7:0] & ~tai_pkg::PR_RSVD_MASK;
			end else if (idx == tai_pkg::IDX_LINK) begin
				n.lc = pwdata[5:0];
			end
		end

		// reserved codes park the divider rather than guess a rate
		if (rsv) begin
			n.fine = 8'h00;
			n.phase = 5'h00;
		end else if (s.fine >= div - 8'h01) begin
			n.fine = 8'h00;
			n.dtick = 1'b1;
			if (s.phase == tai_pkg::PHASE_LAST) begin
				n.phase = 5'h00;
				n.btick = 1'b1;
			end else begin
				n.phase = s.phase + 5'h01;
			end
		end else begin
			n.fine = s.fine + 8'h01;
		end
		n.txc_o = !rsv && (s.phase < tai_pkg::TXC_HIGH);

		// elastic buffer, only in the path when the pin paces transmit
		if (!ext || !transmit_start_bit) begin
			n.eb = tai_pkg::EB_IDLE;
			n.wr = 4'h0;
			n.rd = 4'h0;
			n.level = 5'h00;
		end else begin
			case (s.eb)
				tai_pkg::EB_IDLE: begin
					n.eb = tai_pkg::EB_FILL;
				end
				tai_pkg::EB_FILL: begin
					if (s.level == tai_pkg::PREFILL) begin
						n.eb = tai_pkg::EB_RUN;
					end
				end
				tai_pkg::EB_RUN: begin
					pop = edge_ext && (s.level != 5'h00);
				end
				default: begin
					n.eb = tai_pkg::EB_IDLE;
				end
			endcase
			// overflow drops the newest bit; the far clock is too slow
			push = s.btick && (s.eb != tai_pkg::EB_IDLE)
				&& (s.level < tai_pkg::FIFO_DEPTH);
			if (push) begin
				n.fifo[s.wr] = tx_data_bit;
				n.wr = s.wr + 4'h1;
			end
			if (pop) begin
				n.rd = s.rd + 4'h1;
			end
			if (push && !pop) begin
				n.level = s.level + 5'h01;
			end else if (pop && !push) begin
				n.level = s.level - 5'h01;
			end
		end
		if (!ext) begin
			if (s.btick) begin
				n.ser = tx_data_bit;
			end
		end else if (pop) begin
			n.ser = s.fifo[s.rd];
		end

		n.stop = (s.cca[tai_pkg::CCA_SD_BAUD] && baud_stop_div_hit)
			|| (s.cca[tai_pkg::CCA_RSSI] && rssi_above_floor);
		n.cca_o = (s.cca[tai_pkg::CCA_CS_BAUD] && baud_carrier_hit)
			|| (s.cca[tai_pkg::CCA_RSSI] && rssi_above_floor);

		// with the strap set these pins are address lines, never driven
		n.ant_oe = !pcm && s.lc[tai_pkg::LC_ANT_EN];
		n.ant_o = !(s.pin_rate[tai_pkg::PR_ANT_FN]
			&& s.lc[tai_pkg::LC_SW_EN] && diversity_antenna);
		n.txd_oe = !pcm && s.lc[tai_pkg::LC_TXD_EN];
		n.txd_o = !(s.pin_rate[tai_pkg::PR_TXD_FN] && s.ser);
		n.cmd_oe = !pcm && s.lc[tai_pkg::LC_CMD_EN];
		if (!s.pin_rate[tai_pkg::PR_CMD_FN]) begin
			n.cmd_o = 1'b0;
		end else if (s.lc[tai_pkg::LC_RX_EN]) begin
			n.cmd_o = receive_active;
		end else begin
			n.cmd_o = tx_command_level;
		end

		n.gap = s.btick ? 12'h001 : s.gap + 12'h001;
		n.dcnt = s.btick ? 5'h00 : s.dcnt + {4'h0, s.dtick};
		if (wr_acc || rsv) begin
			n.gap_ok = 1'b0;
		end else if (s.btick) begin
			n.gap_ok = 1'b1;
		end

		if (!s.rst_q[1]) begin
			n = S_RST;
			n.strap_q = s.strap_q;
		end
		n.rst_q = {s.rst_q[0], 1'b1};
	end

	// reset release keeps moving while ce is low, so ce cannot hold reset
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s <= S_RST;
		end else if (ce) begin
			s <= n;
		end else begin
			s.rst_q <= n.rst_q;
		end
	end

	assign stop_div_term = s.stop;
	assign cca_term = s.cca_o;
	assign dpll_clock_tick = s.dtick;
	assign tx_bit_strobe = s.btick;
	assign antenna_select_pin_n_o = s.ant_o;
	assign antenna_select_pin_oe = s.ant_oe;
	assign tx_serial_data_pin_n_o = s.txd_o;
	assign tx_serial_data_pin_oe = s.txd_oe;
	assign tx_command_pin_o = s.cmd_o;
	assign tx_command_pin_oe = s.cmd_oe;
	assign tx_clock_pin_o = s.txc_o;
	assign tx_clock_pin_oe = !ext;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!s.rst_q[1] || !ce);

	property p_sd_used;
		s.cca[tai_pkg::CCA_SD_BAUD] && baud_stop_div_hit |=> stop_div_term;
	endproperty
	a_sd_used: assert property (p_sd_used)
		else $error("stop-diversity baud count not used");

	property p_sd_ignored;
		!s.cca[tai_pkg::CCA_SD_BAUD] && !s.cca[tai_pkg::CCA_RSSI]
			|=> !stop_div_term;
	endproperty
	a_sd_ignored: assert property (p_sd_ignored)
		else $error("stop term raised with inputs disabled");

	property p_cs_gate;
		s.cca[tai_pkg::CCA_CS_BAUD] == 1'b0 && !s.cca[tai_pkg::CCA_RSSI]
			|=> !cca_term;
	endproperty
	a_cs_gate: assert property (p_cs_gate)
		else $error("channel term raised with inputs disabled");

	property p_rssi;
		s.cca[tai_pkg::CCA_RSSI] && rssi_above_floor
			|=> cca_term && stop_div_term;
	endproperty
	a_rssi: assert property (p_rssi)
		else $error("signal strength not fed to both decisions");

	property p_strap_pins;
		pcm |=> !antenna_select_pin_oe && !tx_serial_data_pin_oe
			&& !tx_command_pin_oe;
	endproperty
	a_strap_pins: assert property (p_strap_pins)
		else $error("multi-function pin driven under strap");

	property p_txc_dir;
		wr_acc && idx == tai_pkg::IDX_PINRATE
			|=> tx_clock_pin_oe == !$past(pwdata[tai_pkg::PR_EXT_TXC]);
	endproperty
	a_txc_dir: assert property (p_txc_dir)
		else $error("tx clock pin direction wrong");

	property p_prefill;
		$rose(s.eb == tai_pkg::EB_RUN) |-> $past(s.level) == tai_pkg::PREFILL;
	endproperty
	a_prefill: assert property (p_prefill)
		else $error("elastic buffer drained before prefill");

	property p_bit_period;
		s.btick && s.gap_ok |-> s.gap == ratio;
	endproperty
	a_bit_period: assert property (p_bit_period)
		else $error("bit strobe period differs from rate");

	property p_dpll_ticks;
		s.btick && s.gap_ok |-> s.dcnt == tai_pkg::PHASE_LAST;
	endproperty
	a_dpll_ticks: assert property (p_dpll_ticks)
		else $error("dpll ticks per bit not twenty");

	sequence s_rev_read;
		psel && !penable && aligned && idx == tai_pkg::IDX_REV
			##1 psel && penable;
	endsequence
	property p_revision;
		s_rev_read |-> prdata[7:0] == REVISION && !pslverr;
	endproperty
	a_revision: assert property (p_revision)
		else $error("revision read wrong");
endmodule : tai_rate_pin_config
`default_nettype wire

//--- dv/phy_model.sv
// far-side transceiver model: external transmit clock source
`timescale 1ns/100ps
`default_nettype none
module phy_model (
	input wire logic run,
	input wire logic [15:0] half_ns,
	output logic tx_clock_pin_i
);
	// own timebase, unrelated in phase to core_clk; stands low outside frames
	initial tx_clock_pin_i = 1'b0;
	always begin
		#(half_ns);
		tx_clock_pin_i = run ? ~tx_clock_pin_i : 1'b0;
	end
endmodule : phy_model
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the pin function and rate register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [7:0] REV_ID = 8'h3C; // arbitrary value
	localparam int RATIOS [16] = '{0, 20, 40, 80, 0, 200, 2000, 0,
		20, 40, 80, 160, 0, 400, 4000, 0};
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [2:0] hits = 3'h0;
	logic div_ant = 1'b0;
	logic start = 1'b0;
	logic dbit = 1'b0;
	logic cmd_lvl = 1'b0;
	logic rx_act = 1'b0;
	logic strap = 1'b0;
	logic run = 1'b0;
	logic pready, pslverr, sd_term, cca_term, tick, strobe;
	logic ant_n, ant_oe, txd_n, txd_oe, cmd_o, cmd_oe, txc_i, txc_o, txc_oe;
	int n_errors = 0;
	int checked = 0;
	always #12.5 core_clk = ~core_clk;
	tai_rate_pin_config #(.REVISION(REV_ID)) dut (.core_clk(core_clk),
		.nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .baud_stop_div_hit(hits[2]),
		.baud_carrier_hit(hits[1]), .rssi_above_floor(hits[0]),
		.stop_div_term(sd_term), .cca_term(cca_term),
		.diversity_antenna(div_ant), .transmit_start_bit(start),
		.tx_data_bit(dbit), .tx_command_level(cmd_lvl),
		.receive_active(rx_act), .dpll_clock_tick(tick),
		.tx_bit_strobe(strobe), .bus_mode_strap(strap),
		.antenna_select_pin_n_o(ant_n), .antenna_select_pin_oe(ant_oe),
		.tx_serial_data_pin_n_o(txd_n), .tx_serial_data_pin_oe(txd_oe),
		.tx_command_pin_o(cmd_o), .tx_command_pin_oe(cmd_oe),
		.tx_clock_pin_i(txc_i), .tx_clock_pin_o(txc_o),
		.tx_clock_pin_oe(txc_oe));
	phy_model partner (.run(run), .half_ns(16'h0101), .tx_clock_pin_i(txc_i));
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x,
		input logic ex);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 8'h00, q, e);
		chk("prdata", {24'h0, x}, q);
		chk("pslverr", {31'h0, ex}, {31'h0, e});
	endtask : rd
	task automatic t_reset;
		chk("txc oe", 32'h0, {31'h0, txc_oe});
		rd(8'h70, 8'h00, 1'b0);
		rd(8'h78, 8'h09, 1'b0);
		wr(8'h7C, 8'hFF);
		rd(8'h7C, REV_ID, 1'b0);
		wr(8'h74, 8'h00);
		rd(8'hF0, 8'h00, 1'b1);
	endtask : t_reset
	task automatic t_cca;
		logic e_sd, e_cca;
		for (int c = 0; c < 8; c++) begin
			wr(8'h70, 8'(c));
			for (int h = 0; h < 8; h++) begin
				hits <= 3'(h);
				repeat (3) @(posedge core_clk);
				e_sd = (c[2] & h[2]) | (c[0] & h[0]);
				e_cca = (c[1] & h[1]) | (c[0] & h[0]);
				chk("sd", {31'h0, e_sd}, {31'h0, sd_term});
				chk("cca", {31'h0, e_cca}, {31'h0, cca_term});
			end
		end
	endtask : t_cca
	task automatic pins(input logic [4:0] x);
		logic [4:0] g;
		repeat (5) @(posedge core_clk);
		g = {ant_oe, ant_n, txd_oe, cmd_oe, cmd_o};
		chk("pins", {27'h0, x}, {27'h0, g});
	endtask : pins
	task automatic t_pins;
		div_ant <= 1'b1;
		rx_act <= 1'b1;
		wr(8'h80, 8'h3E);
		rd(8'h80, 8'h3E, 1'b0);
		wr(8'h78, 8'hE1);
		rd(8'h78, 8'hE1, 1'b0);
		pins(5'h17);
		rx_act <= 1'b0;
		cmd_lvl <= 1'b1;
		wr(8'h80, 8'h0E);
		pins(5'h1F);
		wr(8'h78, 8'h01);
		pins(5'h1E);
		strap <= 1'b1;
		pins(5'h08);
		strap <= 1'b0;
	endtask : t_pins
	task automatic t_rate;
		int n, per, ticks, hi, lim;
		for (int k = 0; k < 16; k++) begin
			// ratios do not depend on the real input frequency
			wr(8'h80, {7'h0, k[3]});
			wr(8'h78, {5'h0, k[2:0]});
			lim = RATIOS[k] ? 2 * RATIOS[k] + 5 : 50;
			{n, per, ticks, hi} = '0;
			do begin
				@(posedge core_clk);
				n++;
				ticks += int'(tick === 1'b1);
			end while (strobe !== 1'b1 && n < lim);
			if (strobe === 1'b1) begin
				ticks = 0;
				do begin
					@(posedge core_clk);
					per++;
					ticks += int'(tick === 1'b1);
					hi += int'(txc_o === 1'b1);
				end while (strobe !== 1'b1 && per < lim);
			end
			chk("period", RATIOS[k], per);
			chk("ticks", RATIOS[k] ? 20 : 0, ticks);
			chk("txc high", RATIOS[k] / 2, hi);
			chk("txc oe", 32'h1, {31'h0, txc_oe});
			rd(8'h84, {7'h0, RATIOS[k] == 0}, 1'b0);
		end
	endtask : t_rate
	task automatic bits_to_data(output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			n += int'(strobe === 1'b1);
		end while (txd_n !== 1'b0 && n < 12);
	endtask : bits_to_data
	task automatic t_tx;
		int n;
		wr(8'h80, 8'h04);
		wr(8'h78, 8'h41);
		dbit <= 1'b1;
		start <= 1'b1;
		bits_to_data(n);
		chk("internal delay", 32'h1, n);
		dbit <= 1'b0;
		repeat (45) @(posedge core_clk);
		start <= 1'b0;
		wr(8'h78, 8'h49);
		run <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("txc oe", 32'h0, {31'h0, txc_oe});
		dbit <= 1'b1;
		start <= 1'b1;
		bits_to_data(n);
		// one external clock period of slack after the prefill
		chk("external delay", 32'h1, 32'(n >= 8 && n <= 9));
		run <= 1'b0;
		start <= 1'b0;
	endtask : t_tx
	// clock enable low must freeze the divider; then reset again mid-run
	task automatic t_hold;
		logic v;
		int n;
		ce <= 1'b0;
		repeat (2) @(posedge core_clk);
		v = txc_o;
		n = 0;
		repeat (40) begin
			@(posedge core_clk);
			n += int'(txc_o !== v);
		end
		chk("frozen txc", 32'h0, n);
		ce <= 1'b1;
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(8'h78, 8'h09, 1'b0);
		chk("txc oe", 32'h0, {31'h0, txc_oe});
	endtask : t_hold
	task automatic test_done;
		if (n_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	initial begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		test_done;
	end
	initial begin
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset;
		t_cca;
		t_pins;
		t_rate;
		t_tx;
		t_hold;
		test_done;
	end
endmodule : testbench
`default_nettype wire
